/* include/pss_pkg.sv */
// shared constants and types of the serially loaded synthesizer control block
// Operation
// R01: step bit low: current bits give 70, 80, 90 or 100 percent pump current.
// R02: step bit high, pin A not port: 25, 50, 75 or 100 percent.
// R03: pin A in port mode forces the 10 percent step table.
// R04: port mode drives pin A from config bit 1, unaffected by standby.
// R05: config bit 0 high releases open-drain pin B, low drives it low.
// R06: polarity bit inverts pump polarity and swaps the detector pair outputs.
// R07: detector select high: pump on, pair high; low: pair on, pump floats.
// R08: lock enable low holds lock indicator statically low.
// R09: standby floats pump, pair high, counters stop, registers kept.
// R10: in standby lock indicator is low, or static high when enabled.
// R11: leaving standby, counters run but detector pulses stay blocked.
// R12: first feedback pulse jam-loads reference counter, then detectors see pulses.
// R13: an 8-clock transfer loads only the configuration register.
// R14: 24-clock transfer loads divider word and moves reference buffer one into two.
// R15: host keeps main count not below swallow count; total is main*64+swallow.
// R16: at power-on pin A is the serial data output for cascading.
// R17: 16-clock transfer applies mode bits at once, low 13 bits to buffer one.
// R18: reference counter finishes its present cycle before taking a new ratio.
// R19: host keeps serial clock low during a bare strobe that moves the buffer.
// R20: at power-on the divided reference output runs at one eighth.
// R21: prescaler divides by 65 with modulus control low, by 64 when high.
// R22: host initialises by strobing with serial clock held high.
// R23: mode codes: 001 oscillator, 000 stop, 011 one-to-one, 111 by 16, 010 off.
// R24: a 16-clock transfer is routed to the reference register.
// R25: data shifts MSB first on rising clock while strobe low; count picks register.
package pss_pkg;
    localparam int CFG_W = 8;
    localparam int FDIV_W = 24;
    localparam int RDIV_W = 16;
    localparam int RCNT_W = 13;
    localparam int NCNT_W = 12;
    localparam int ACNT_W = 6;
    localparam int BITCNT_W = 5;
    localparam int PCT_W = 7;
    // configuration bit positions
    localparam int CFG_POL_BIT = 7;
    localparam int CFG_DETSEL_BIT = 6;
    localparam int CFG_LOCKEN_BIT = 5;
    localparam int CFG_HOLD_BIT = 4;
    localparam int CFG_CUR_HI_BIT = 3;
    localparam int CFG_CUR_LO_BIT = 2;
    localparam int CFG_PORT_BIT = 1;
    localparam int CFG_OUTB_BIT = 0;
    // divider word fields
    localparam int FDIV_AMODE_HI = 23;
    localparam int FDIV_AMODE_LO = 22;
    localparam int FDIV_N_HI = 17;
    localparam int FDIV_N_LO = 6;
    localparam int FDIV_A_HI = 5;
    localparam int FDIV_A_LO = 0;
    // reference word fields
    localparam int RDIV_MODE_HI = 15;
    localparam int RDIV_MODE_LO = 13;
    localparam int RDIV_CNT_HI = 12;
    // transfer lengths
    localparam logic [BITCNT_W-1:0] XFER_CFG = 5'h08;
    localparam logic [BITCNT_W-1:0] XFER_REF = 5'h10;
    localparam logic [BITCNT_W-1:0] XFER_FDIV = 5'h18;
    localparam logic [BITCNT_W-1:0] XFER_NONE = 5'h00;
    localparam logic [BITCNT_W-1:0] XFER_SAT = 5'h1f;
    // values after reset
    localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
    localparam logic [FDIV_W-1:0] FDIV_RST = 24'h00_0000;
    localparam logic [RCNT_W-1:0] RCNT_RST = 13'h0001;
    localparam logic [2:0] RMODE_RST = 3'h6;
    // reference oscillator / divider modes
    localparam logic [2:0] RMODE_STOP = 3'h0;
    localparam logic [2:0] RMODE_XTAL = 3'h1;
    localparam logic [2:0] RMODE_OFF = 3'h2;
    localparam logic [2:0] RMODE_DIV1 = 3'h3;
    localparam logic [2:0] RMODE_DIV2 = 3'h4;
    localparam logic [2:0] RMODE_DIV4 = 3'h5;
    localparam logic [2:0] RMODE_DIV8 = 3'h6;
    localparam logic [2:0] RMODE_DIV16 = 3'h7;
    // pin A functions
    localparam logic [1:0] AMODE_DATA = 2'h0;
    localparam logic [1:0] AMODE_REFP = 2'h1;
    localparam logic [1:0] AMODE_FBP = 2'h2;
    localparam logic [1:0] AMODE_PORT = 2'h3;
    // prescaler moduli
    localparam logic [PCT_W-1:0] PRESC_LOW_MOD = 7'h41;
    localparam logic [PCT_W-1:0] PRESC_HIGH_MOD = 7'h40;
    // pump current in percent
    localparam logic [PCT_W-1:0] PCT_25 = 7'h19;
    localparam logic [PCT_W-1:0] PCT_50 = 7'h32;
    localparam logic [PCT_W-1:0] PCT_70 = 7'h46;
    localparam logic [PCT_W-1:0] PCT_75 = 7'h4b;
    localparam logic [PCT_W-1:0] PCT_80 = 7'h50;
    localparam logic [PCT_W-1:0] PCT_90 = 7'h5a;
    localparam logic [PCT_W-1:0] PCT_100 = 7'h64;

    typedef enum logic [2:0] {
        PSS_RUN = 3'h1,
        PSS_HOLD = 3'h2,
        PSS_WAKE = 3'h4
    } pss_pwr_t;
endpackage

/* verilog/pss_pin_sync.sv */
// three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps
`default_nettype none
module pss_pin_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
        logic [W-1:0] rise;
        logic [W-1:0] fall;
    } pss_sync_t;

    pss_sync_t st_q;
    pss_sync_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.lvl[i] = st_q.s3[i];
            end
        end
        st_d.rise = st_d.lvl & ~st_q.lvl;
        st_d.fall = ~st_d.lvl & st_q.lvl;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.lvl;
    assign rise = st_q.rise;
    assign fall = st_q.fall;
endmodule
`default_nettype wire

/* verilog/pss_reload_counter.sv */
// down counter that reloads at the end of each cycle and pulses once per cycle
`timescale 1ns/100ps
`default_nettype none
module pss_reload_counter #(
    parameter int W = 13
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic tick,
    input wire logic hold,
    input wire logic jam,
    input wire logic [W-1:0] load_val,
    output logic cycle_end
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic pulse;
    } pss_cnt_t;

    pss_cnt_t st_q;
    pss_cnt_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.pulse = 1'b0;
        if (jam) begin
            st_d.cnt = load_val;
        end else if (tick && !hold) begin
            // apart from a jam, which loads at once, a new ratio is taken only at the end of the present cycle
            if (st_q.cnt <= W'(1)) begin
                st_d.cnt = load_val; // R18
                st_d.pulse = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt - W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign cycle_end = st_q.pulse;
endmodule
`default_nettype wire

/* verilog/pss_synth_ctrl.sv */
// serially loaded control registers, counters and detectors of the synthesizer
`timescale 1ns/100ps
`default_nettype none
module pss_synth_ctrl (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic serial_latch_strobe,
    input wire logic reference_clock_in,
    input wire logic rf_clock_in,
    output logic reference_divided_out,
    output logic pump_source,
    output logic pump_sink,
    output logic pump_oe,
    output logic [6:0] pump_current_level,
    output logic detector_ref_out,
    output logic detector_fb_out,
    output logic lock_indicator,
    output logic general_out_a,
    output logic general_out_b,
    output logic general_out_b_oe,
    output logic modulus_control,
    output logic prescaler_out
);
    typedef struct packed {
        logic [pss_pkg::CFG_W-1:0] cfg;
        logic [pss_pkg::FDIV_W-1:0] fdiv;
        logic [pss_pkg::RCNT_W-1:0] rbuf1;
        logic [pss_pkg::RCNT_W-1:0] rbuf2;
        logic [2:0] rmode;
        logic [pss_pkg::FDIV_W-1:0] shift;
        logic [pss_pkg::BITCNT_W-1:0] bit_cnt;
        pss_pkg::pss_pwr_t pwr;
        logic [pss_pkg::ACNT_W-1:0] a_cnt;
        logic [pss_pkg::NCNT_W-1:0] n_cnt;
        logic mod_ctrl;
        logic fb_pulse;
        logic up;
        logic dn;
        logic [3:0] ref_div;
        logic ref_out;
        logic [pss_pkg::PCT_W-1:0] pct;
        logic phi_r;
        logic phi_v;
        logic lock;
        logic src;
        logic snk;
        logic oe;
        logic out_a;
        logic out_b_oe;
    } pss_state_t;

    pss_state_t st_q;
    pss_state_t st_d;

    logic sclk_lvl;
    logic sclk_rise;
    logic sdata_lvl;
    logic strobe_lvl;
    logic strobe_rise;
    logic reference_clock_in_lvl;
    logic reference_clock_in_rise;
    logic rf_rise;
    logic ref_pulse;
    logic presc_pulse;
    logic port_mode;
    logic ref_run;
    logic jam_ref;
    logic [pss_pkg::PCT_W-1:0] presc_mod;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    pss_pin_sync #(
        .W(1)
    ) u_sync_sclk (
        .ref_clk(ref_clk),
        .srst(srst),
        .pin_in(serial_clock),
        .level(sclk_lvl),
        .rise(sclk_rise),
        .fall()
    );

    pss_pin_sync #(
        .W(1)
    ) u_sync_sdata (
        .ref_clk(ref_clk),
        .srst(srst),
        .pin_in(serial_data),
        .level(sdata_lvl),
        .rise(),
        .fall()
    );

    pss_pin_sync #(
        .W(1)
    ) u_sync_strobe (
        .ref_clk(ref_clk),
        .srst(srst),
        .pin_in(serial_latch_strobe),
        .level(strobe_lvl),
        .rise(strobe_rise),
        .fall()
    );

    pss_pin_sync #(
        .W(1)
    ) u_sync_reference_clock_in (
        .ref_clk(ref_clk),
        .srst(srst),
        .pin_in(reference_clock_in),
        .level(reference_clock_in_lvl),
        .rise(reference_clock_in_rise),
        .fall()
    );

    pss_pin_sync #(
        .W(1)
    ) u_sync_rf (
        .ref_clk(ref_clk),
        .srst(srst),
        .pin_in(rf_clock_in),
        .level(),
        .rise(rf_rise),
        .fall()
    );

    ////////////////////////////////////////////////////////////////////////////
    // reference counter and prescaler

    // stopped oscillator gives the reference counter no edges
    assign ref_run = reference_clock_in_rise && (st_q.rmode != pss_pkg::RMODE_STOP); // R23
    assign jam_ref = (st_q.pwr == pss_pkg::PSS_WAKE) && st_q.fb_pulse; // R12
    assign presc_mod = st_q.mod_ctrl ? pss_pkg::PRESC_HIGH_MOD : pss_pkg::PRESC_LOW_MOD; // R21

    pss_reload_counter #(
        .W(pss_pkg::RCNT_W)
    ) u_ref_counter (
        .ref_clk(ref_clk),
        .srst(srst),
        .tick(ref_run),
        .hold(st_q.pwr == pss_pkg::PSS_HOLD),
        .jam(jam_ref),
        .load_val(st_q.rbuf2),
        .cycle_end(ref_pulse)
    );

    pss_reload_counter #(
        .W(pss_pkg::PCT_W)
    ) u_prescaler (
        .ref_clk(ref_clk),
        .srst(srst),
        .tick(rf_rise),
        .hold(st_q.pwr == pss_pkg::PSS_HOLD),
        .jam(1'b0),
        .load_val(presc_mod),
        .cycle_end(presc_pulse)
    );

    assign port_mode = st_q.fdiv[pss_pkg::FDIV_AMODE_HI:pss_pkg::FDIV_AMODE_LO] == pss_pkg::AMODE_PORT;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic fr_gate;
        logic fv_gate;
        logic hold;
        logic step25;
        logic [1:0] cur;
        fr_gate = 1'b0;
        fv_gate = 1'b0;
        hold = 1'b0;
        step25 = 1'b0;
        cur = 2'h0;
        st_d = st_q;
        st_d.fb_pulse = 1'b0;

        // serial shift, MSB first while the strobe is low
        if (sclk_rise && !strobe_lvl) begin
            st_d.shift = {st_q.shift[pss_pkg::FDIV_W-2:0], sdata_lvl}; // R25
            if (st_q.bit_cnt != pss_pkg::XFER_SAT) begin
                st_d.bit_cnt = st_q.bit_cnt + pss_pkg::BITCNT_W'(1);
            end
        end

        // latch on the rising strobe, register picked by the bit count
        if (strobe_rise) begin
            st_d.bit_cnt = pss_pkg::XFER_NONE;
            if (sclk_lvl) begin
                // strobe with serial clock high initialises the registers
                st_d.cfg = pss_pkg::CFG_RST;
                st_d.fdiv = pss_pkg::FDIV_RST;
                st_d.rmode = pss_pkg::RMODE_RST;
            end else begin
                case (st_q.bit_cnt)
                    pss_pkg::XFER_CFG: begin
                        st_d.cfg = st_q.shift[pss_pkg::CFG_W-1:0]; // R13
                    end
                    pss_pkg::XFER_REF: begin
                        st_d.rmode = st_q.shift[pss_pkg::RDIV_MODE_HI:pss_pkg::RDIV_MODE_LO]; // R17 R24
                        st_d.rbuf1 = st_q.shift[pss_pkg::RDIV_CNT_HI:0]; // R17
                    end
                    pss_pkg::XFER_FDIV: begin
                        st_d.fdiv = st_q.shift; // R14
                        st_d.rbuf2 = st_q.rbuf1; // R14
                    end
                    pss_pkg::XFER_NONE: begin
                        st_d.rbuf2 = st_q.rbuf1; // R19
                    end
                    default: begin
                    end
                endcase
            end
        end

        // standby and the two-step recovery
        case (st_q.pwr)
            pss_pkg::PSS_RUN: begin
                if (st_q.cfg[pss_pkg::CFG_HOLD_BIT]) begin
                    st_d.pwr = pss_pkg::PSS_HOLD; // R09
                end
            end
            pss_pkg::PSS_HOLD: begin
                if (!st_q.cfg[pss_pkg::CFG_HOLD_BIT]) begin
                    st_d.pwr = pss_pkg::PSS_WAKE; // R11
                end
            end
            pss_pkg::PSS_WAKE: begin
                if (st_q.cfg[pss_pkg::CFG_HOLD_BIT]) begin
                    st_d.pwr = pss_pkg::PSS_HOLD;
                end else if (st_q.fb_pulse) begin
                    st_d.pwr = pss_pkg::PSS_RUN; // R12
                end
            end
            default: begin
                st_d.pwr = pss_pkg::PSS_RUN;
            end
        endcase
        hold = st_q.pwr == pss_pkg::PSS_HOLD;

        // main and swallow counters around the prescaler
        if (presc_pulse && !hold) begin
            if (st_q.n_cnt <= pss_pkg::NCNT_W'(1)) begin
                st_d.n_cnt = st_q.fdiv[pss_pkg::FDIV_N_HI:pss_pkg::FDIV_N_LO]; // R15
                st_d.a_cnt = st_q.fdiv[pss_pkg::FDIV_A_HI:pss_pkg::FDIV_A_LO];
                st_d.fb_pulse = 1'b1;
            end else begin
                st_d.n_cnt = st_q.n_cnt - pss_pkg::NCNT_W'(1);
                if (st_q.a_cnt != '0) begin
                    st_d.a_cnt = st_q.a_cnt - pss_pkg::ACNT_W'(1);
                end
            end
        end
        st_d.mod_ctrl = st_d.a_cnt == '0; // R21

        // phase/frequency detector, pulses only while running
        fr_gate = ref_pulse && (st_q.pwr == pss_pkg::PSS_RUN); // R11
        fv_gate = st_q.fb_pulse && (st_q.pwr == pss_pkg::PSS_RUN); // R11
        if (st_q.pwr != pss_pkg::PSS_RUN) begin
            st_d.up = 1'b0; // R12
            st_d.dn = 1'b0;
        end else if (st_q.up && st_q.dn) begin
            st_d.up = fr_gate;
            st_d.dn = fv_gate;
        end else begin
            st_d.up = st_q.up | fr_gate;
            st_d.dn = st_q.dn | fv_gate;
        end

        // detector outputs
        if (st_q.cfg[pss_pkg::CFG_DETSEL_BIT] && !hold) begin
            st_d.oe = st_q.up ^ st_q.dn; // R07
            st_d.src = st_q.cfg[pss_pkg::CFG_POL_BIT] ? st_q.dn : st_q.up; // R06
            st_d.snk = st_q.cfg[pss_pkg::CFG_POL_BIT] ? st_q.up : st_q.dn; // R06
        end else begin
            st_d.oe = 1'b0; // R07 R09
            st_d.src = 1'b0;
            st_d.snk = 1'b0;
        end
        if (!st_q.cfg[pss_pkg::CFG_DETSEL_BIT] && !hold) begin
            st_d.phi_r = st_q.cfg[pss_pkg::CFG_POL_BIT] ? ~st_q.dn : ~st_q.up; // R06
            st_d.phi_v = st_q.cfg[pss_pkg::CFG_POL_BIT] ? ~st_q.up : ~st_q.dn; // R06
        end else begin
            st_d.phi_r = 1'b1; // R07 R09
            st_d.phi_v = 1'b1;
        end

        // lock indicator
        if (!st_q.cfg[pss_pkg::CFG_LOCKEN_BIT]) begin
            st_d.lock = 1'b0; // R08 R10
        end else if (hold) begin
            st_d.lock = 1'b1; // R10
        end else begin
            st_d.lock = ~st_q.up & ~st_q.dn;
        end

        // pump current table
        cur = {st_q.cfg[pss_pkg::CFG_CUR_HI_BIT], st_q.cfg[pss_pkg::CFG_CUR_LO_BIT]};
        step25 = st_q.cfg[pss_pkg::CFG_PORT_BIT] && !port_mode; // R02 R03
        case (cur)
            2'h0: st_d.pct = step25 ? pss_pkg::PCT_25 : pss_pkg::PCT_70; // R01 R02
            2'h1: st_d.pct = step25 ? pss_pkg::PCT_50 : pss_pkg::PCT_80; // R01 R02
            2'h2: st_d.pct = step25 ? pss_pkg::PCT_75 : pss_pkg::PCT_90; // R01 R02
            default: st_d.pct = pss_pkg::PCT_100; // R01 R02
        endcase

        // general outputs
        case (st_q.fdiv[pss_pkg::FDIV_AMODE_HI:pss_pkg::FDIV_AMODE_LO])
            pss_pkg::AMODE_DATA: st_d.out_a = st_q.shift[pss_pkg::FDIV_W-1]; // R16
            pss_pkg::AMODE_REFP: st_d.out_a = ref_pulse;
            pss_pkg::AMODE_FBP: st_d.out_a = st_q.fb_pulse;
            default: st_d.out_a = st_q.cfg[pss_pkg::CFG_PORT_BIT]; // R04
        endcase
        st_d.out_b_oe = ~st_q.cfg[pss_pkg::CFG_OUTB_BIT]; // R05

        // divided reference output
        if (reference_clock_in_rise && (st_q.rmode != pss_pkg::RMODE_STOP)) begin
            st_d.ref_div = st_q.ref_div + 4'h1;
        end
        case (st_q.rmode)
            pss_pkg::RMODE_XTAL: st_d.ref_out = reference_clock_in_lvl; // R23
            pss_pkg::RMODE_DIV1: st_d.ref_out = reference_clock_in_lvl; // R23
            pss_pkg::RMODE_DIV2: st_d.ref_out = st_q.ref_div[0];
            pss_pkg::RMODE_DIV4: st_d.ref_out = st_q.ref_div[1];
            pss_pkg::RMODE_DIV8: st_d.ref_out = st_q.ref_div[2]; // R20
            pss_pkg::RMODE_DIV16: st_d.ref_out = st_q.ref_div[3]; // R23
            default: st_d.ref_out = 1'b0; // R23
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_q <= '0;
            st_q.cfg <= pss_pkg::CFG_RST; // R05 R06 R07 R08
            st_q.fdiv <= pss_pkg::FDIV_RST; // R16
            st_q.rmode <= pss_pkg::RMODE_RST; // R20
            st_q.rbuf1 <= pss_pkg::RCNT_RST;
            st_q.rbuf2 <= pss_pkg::RCNT_RST;
            st_q.pwr <= pss_pkg::PSS_RUN;
            st_q.phi_r <= 1'b1;
            st_q.phi_v <= 1'b1;
            st_q.out_b_oe <= 1'b1; // R05
            st_q.pct <= pss_pkg::PCT_70;
        end else begin
            st_q <= st_d;
        end
    end

    assign reference_divided_out = st_q.ref_out;
    assign pump_source = st_q.src;
    assign pump_sink = st_q.snk;
    assign pump_oe = st_q.oe;
    assign pump_current_level = st_q.pct;
    assign detector_ref_out = st_q.phi_r;
    assign detector_fb_out = st_q.phi_v;
    assign lock_indicator = st_q.lock;
    assign general_out_a = st_q.out_a;
    assign general_out_b = 1'b0;
    assign general_out_b_oe = st_q.out_b_oe;
    assign modulus_control = st_q.mod_ctrl;
    assign prescaler_out = presc_pulse;
endmodule
`default_nettype wire

/* test/pss_chk.sv */
// assertion checker for the synthesizer control block
`timescale 1ns/100ps
`default_nettype none
module pss_chk (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic serial_clock,
    input wire logic serial_latch_strobe,
    input wire logic pump_oe,
    input wire logic [6:0] pump_current_level,
    input wire logic detector_ref_out,
    input wire logic detector_fb_out,
    input wire logic lock_indicator,
    input wire logic general_out_b,
    input wire logic general_out_b_oe,
    input wire logic prescaler_out
);
    logic strb_q;
    logic [4:0] since_q;
    // cycles since the last strobe rise, saturating
    always_ff @(posedge ref_clk) begin
        strb_q <= serial_latch_strobe;
        if (srst)
            since_q <= 5'h1f;
        else if (serial_latch_strobe && !strb_q)
            since_q <= 5'h00;
        else if (since_q != 5'h1f)
            since_q <= since_q + 5'h01;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////
    sequence s_init_cmd;
        $rose(serial_latch_strobe) && serial_clock;
    endsequence
    sequence s_rest;
        general_out_b_oe && !pump_oe && !lock_indicator && pump_current_level == 7'h46;
    endsequence
    AST_INIT: assert property (s_init_cmd |-> ##[3:14] s_rest)
        else $error("init defaults wrong");
    AST_RST: assert property (disable iff (1'b0) srst |=>
        detector_ref_out && detector_fb_out && general_out_b_oe && !lock_indicator) else $error("reset values wrong");
    AST_PUMP_PAIR: assert property (pump_oe |-> detector_ref_out && detector_fb_out)
        else $error("pair low while pump on");
    AST_OUTB: assert property (!general_out_b)
        else $error("pin b not low");
    AST_PCT: assert property (pump_current_level inside {7'h19, 7'h32, 7'h46, 7'h4b, 7'h50, 7'h5a, 7'h64})
        else $error("pump level bad");
    AST_PCT_HOLD: assert property ($changed(pump_current_level) |-> since_q < 5'h10)
        else $error("pump level moved");
    AST_BOE_HOLD: assert property ($changed(general_out_b_oe) |-> since_q < 5'h10)
        else $error("pin b moved");
    AST_PRESC: assert property (prescaler_out |=> !prescaler_out)
        else $error("prescaler pulse long");
endmodule
bind pss_synth_ctrl pss_chk pss_chk_inst (.*);
`default_nettype wire

/* test/pss_host_model.sv */
// serial host model driving the control port
`timescale 1ns/100ps
`default_nettype none
module pss_host_model (
    input wire logic ref_clk,
    output logic serial_clock,
    output logic serial_data,
    output logic serial_latch_strobe
);
    initial begin
        serial_clock = 1'b0;
        serial_data = 1'b0;
        serial_latch_strobe = 1'b1;
    end
    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////
    // n bits msb first; zero bits gives a bare strobe
    task automatic xfer(input logic [23:0] w, input int n, input logic init);
        step(1);
        serial_latch_strobe = 1'b0;
        step(4);
        for (int i = n - 1; i >= 0; i--) begin
            serial_data = w[i];
            step(4);
            serial_clock = 1'b1;
            step(4);
            serial_clock = 1'b0;
        end
        serial_data = ~serial_data;
        serial_clock = init;
        step(4);
        serial_latch_strobe = 1'b1;
        step(4);
        serial_clock = 1'b0;
        step(4);
    endtask
endmodule
`default_nettype wire

/* test/pss_synth_ctrl_tb.sv */
// self-checking bench for the synthesizer control block
`timescale 1ns/100ps
`default_nettype none
module pss_synth_ctrl_tb;
    typedef struct packed {logic [7:0] cfg; logic [6:0] pct;} pss_row_t;
    typedef struct packed {logic [23:0] w; logic [4:0] n; logic [15:0] per;} pss_step_t;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic reference_clock_in = 1'b0;
    logic rf_clock_in = 1'b0;
    logic serial_clock, serial_data, serial_latch_strobe, reference_divided_out, pump_source, pump_sink;
    logic pump_oe, detector_ref_out, detector_fb_out, lock_indicator, general_out_a, general_out_b;
    logic general_out_b_oe, modulus_control, prescaler_out;
    logic [6:0] pump_current_level;
    logic [15:0] p;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;
    pss_row_t rows [11] = '{'{8'h00, 7'h46}, '{8'h05, 7'h50}, '{8'h08, 7'h5a}, '{8'h0d, 7'h64},
        '{8'h02, 7'h19}, '{8'h06, 7'h32}, '{8'h0a, 7'h4b}, '{8'h0e, 7'h64},
        '{8'h30, 7'h46}, '{8'h11, 7'h46}, '{8'h40, 7'h46}};
    // pin A periods: N*64+A rf edges of 4 cycles, or ref pulses of 16
    pss_step_t steps [7] = '{'{24'h80_0081, 5'h18, 16'h0204}, '{24'h80_0040, 5'h18, 16'h0100},
        '{24'h40_0040, 5'h18, 16'h0010}, '{24'h00_c004, 5'h10, 16'h0010}, '{24'h00_0000, 5'h00, 16'h0040},
        '{24'h00_c002, 5'h10, 16'h0040}, '{24'h40_0040, 5'h18, 16'h0020}};
    logic [15:0] ref_per [8] = '{16'h0000, 16'h0010, 16'h0000, 16'h0010, 16'h0020, 16'h0040, 16'h0080, 16'h0100};
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        #1;
        cyc = cyc + 1;
        reference_clock_in = cyc[3];
        rf_clock_in = cyc[1];
        if (cyc == 80000) begin
            fails++;
            $display("[ERR] run length limit reached");
            complete_run();
        end
    end
    pss_synth_ctrl pss_synth_ctrl_inst (.*);
    pss_host_model pss_host_model_inst (.*);
    wire logic [1:0] outs = {general_out_a, reference_divided_out};
    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cfg_w(input logic [23:0] w, input int n, input logic init = 1'b0);
        pss_host_model_inst.xfer(w, n, init);
        repeat (16) @(posedge ref_clk);
    endtask
    // cycles between 2nd and 3rd rise, 0 if quiet
    task automatic period(input logic s, output logic [15:0] q);
        int r = 0;
        logic v = outs[s];
        q = 16'h0000;
        for (int n = 0; n < 4000 && r < 3; n++) begin
            @(posedge ref_clk);
            #2;
            q = q + 16'h0001;
            if (outs[s] && !v) begin
                r++;
                if (r < 3)
                    q = 16'h0000;
            end
            v = outs[s];
        end
        if (r < 3)
            q = 16'h0000;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        period(1'b0, p);
        check("ref out period", 16'h0080, p);
        foreach (rows[i]) begin
            cfg_w({16'h0000, rows[i].cfg}, 8);
            check("pump level", 16'(rows[i].pct), 16'(pump_current_level));
            check("pin b enable", 16'(!rows[i].cfg[0]), 16'(general_out_b_oe));
            check("lock", 16'(rows[i].cfg[5] && rows[i].cfg[4]), 16'(lock_indicator));
            if (rows[i].cfg[6] || rows[i].cfg[4])
                check("pair", 16'h0003, 16'({detector_ref_out, detector_fb_out}));
            if (!rows[i].cfg[6] || rows[i].cfg[4])
                check("pump drive", 16'h0000, 16'(pump_oe));
        end
        $display("config rows done");
        cfg_w(24'hc0_0040, 24);
        cfg_w(24'h00_0002, 8);
        check("port level", 16'h0046, 16'(pump_current_level));
        check("pin a", 16'h0001, 16'(general_out_a));
        cfg_w(24'h00_0012, 8);
        check("pin a", 16'h0001, 16'(general_out_a));
        cfg_w(24'h00_0000, 8);
        check("pin a", 16'h0000, 16'(general_out_a));
        $display("port tests done");
        foreach (steps[i]) begin
            cfg_w(steps[i].w, steps[i].n);
            period(1'b1, p);
            check("pin a period", steps[i].per, p);
        end
        $display("divider tests done");
        for (int m = 0; m < 8; m++) begin
            cfg_w({8'h00, 3'(m), 13'h0001}, 16);
            period(1'b0, p);
            check("ref out period", ref_per[m], p);
        end
        $display("ref mode tests done");
        cfg_w(24'h00_0001, 8);
        cfg_w(24'h00_7fff, 15, 1'b1);
        check("init pin b", 16'h0001, 16'(general_out_b_oe));
        check("init level", 16'h0046, 16'(pump_current_level));
        cfg_w(24'h00_0021, 8);
        srst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check("reset pin b", 16'h0001, 16'(general_out_b_oe));
        check("reset lock", 16'h0000, 16'(lock_indicator));
        $display("init and reset tests done");
        complete_run();
    end
endmodule
`default_nettype wire
